/* cc_channel.sv */
`timescale 1ns/10ps
`include "ccu_consts.svh"
module cc_channel
  import ccu_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  // Configuration
  input wire logic cap_sel,
  input wire logic [`SEL_W-1:0] edge_sel,
  input wire logic [`SEL_W-1:0] in_sel,
  input wire logic sync_cap,
  // Pins
  input wire logic in_a,
  input wire logic in_b,
  // Software access
  input wire logic buf_wr,
  input wire cnt_t wdata,
  input wire logic buf_rd,
  input wire logic flag_clr,
  input wire logic cov_clr,
  // Counter side
  cc_link_if.chan lnk
);
  logic a_meta_r, a_sync_r, b_meta_r, b_sync_r;
  logic lvl_r, pend_r, unread_r, level, det, cap_ev;
  cnt_t buf_r, latch_r;
  logic flag_r, cov_r;

  // Pins are asynchronous, two stages before use
  always_ff @(posedge clk) begin
    a_meta_r <= in_a;
    a_sync_r <= a_meta_r;
    b_meta_r <= in_b;
    b_sync_r <= b_meta_r;
  end

  always_comb begin
    unique case (in_sel)
      `SEL_A: level = a_sync_r;
      `SEL_B: level = b_sync_r;
      `SEL_GND: level = 1'b0;
      default: level = 1'b1;
    endcase
  end

  // Successive samples, one edge gives one event
  always_comb begin
    unique case (edge_sel)
      `EDGE_RISE: det = level & ~lvl_r;
      `EDGE_FALL: det = ~level & lvl_r;
      `EDGE_BOTH: det = level ^ lvl_r;
      default: det = 1'b0;
    endcase
    det = det & cap_sel;
  end

  // Synchronised capture waits for the following clock edge
  assign cap_ev = (det & ~sync_cap) | pend_r;

  // Level tracks the input through reset, so release brings no false edge
  always_ff @(posedge clk) begin
    lvl_r <= level;
    if (rst) pend_r <= 1'b0;
    else pend_r <= det & sync_cap;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      buf_r <= `CNT_RST;
      latch_r <= `CNT_RST;
    end else begin
      if (cap_ev) buf_r <= lnk.count;
      else if (buf_wr) buf_r <= wdata;
      if (lnk.load_go) latch_r <= buf_r;
    end
  end

  // Set wins over software clear for both flags
  always_ff @(posedge clk) begin
    if (rst) begin
      unread_r <= 1'b0;
      flag_r <= 1'b0;
      cov_r <= 1'b0;
    end else begin
      unread_r <= cap_ev | (unread_r & ~buf_rd);
      flag_r <= cap_ev | lnk.equ | (flag_r & ~flag_clr);
      cov_r <= (cap_ev & unread_r) | (cov_r & ~cov_clr);
    end
  end

  assign lnk.hit = lnk.stepped & (lnk.count == latch_r);
  assign lnk.equ = ~cap_sel & lnk.hit;
  assign lnk.latch = latch_r;
  assign lnk.buffer = buf_r;
  assign lnk.flag = flag_r;
  assign lnk.cov = cov_r;
  assign lnk.level = lvl_r;

  a_cov_second: assert property (@(posedge clk) disable iff (rst)
    cap_ev && unread_r |=> cov_r)
    else $error("overflow not set on second capture");
  a_capture_copy: assert property (@(posedge clk) disable iff (rst)
    cap_ev |=> buf_r == $past(lnk.count) && flag_r)
    else $error("capture value or flag wrong");
endmodule : cc_channel

/* cc_link_if.sv */
`timescale 1ns/10ps
interface cc_link_if;
  import ccu_pkg::*;
  cnt_t count;
  logic stepped;
  logic load_go;
  logic hit;
  logic equ;
  cnt_t latch;
  cnt_t buffer;
  logic flag;
  logic cov;
  logic level;
  modport ctl (output count, stepped, load_go,
               input hit, equ, latch, buffer, flag, cov, level);
  modport chan (input count, stepped, load_go,
                output hit, equ, latch, buffer, flag, cov, level);
endinterface : cc_link_if

/* ccu_consts.svh */
`ifndef CCU_CONSTS_SVH
`define CCU_CONSTS_SVH

// Counter and data width
`define CNT_W 16
// Number of channels, three or seven
`define CH_N 7
// Field widths
`define LM_W 2
`define OM_W 3
`define GRP_W 2
`define SEL_W 2
// Reset values
`define CNT_RST 16'h0000
`define OUT_RST 1'b0
// Input select codes
`define SEL_A 2'h0
`define SEL_B 2'h1
`define SEL_GND 2'h2
`define SEL_VCC 2'h3
// Edge select codes
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3

`endif

/* ccu_far_side.sv */
`timescale 1ns/10ps
`include "ccu_consts.svh"
module ccu_far_side (
  // Clock
  input wire logic clk,
  // Requests from the bench
  input wire logic [`CH_N-1:0] set_a,
  input wire logic [`CH_N-1:0] set_b,
  input wire logic hiz_req,
  // Capture and high-impedance pins
  output logic [`CH_N-1:0] pin_a,
  output logic [`CH_N-1:0] pin_b,
  output logic hiz_pin,
  // Timer output pins
  input wire logic [`CH_N-1:0] out_val,
  input wire logic [`CH_N-1:0] out_en,
  output logic [`CH_N-1:0] pin_level
);
  logic [`CH_N-1:0] last_r;
  // Pins move off the clock grid, as a real source would
  assign #3 pin_a = set_a;
  assign #3 pin_b = set_b;
  assign #4 hiz_pin = hiz_req;
  // Released pins have no pull, so show a changing pattern
  always_ff @(posedge clk) last_r <= pin_level;
  assign pin_level = (out_en & out_val) | (~out_en & ~last_r);
endmodule : ccu_far_side

/* ccu_pkg.sv */
`include "ccu_consts.svh"

package ccu_pkg;
  typedef logic [`CNT_W-1:0] cnt_t;
  typedef enum logic [1:0] {MODE_STOP, MODE_UP, MODE_CONT, MODE_UPDN} count_mode_e;
  typedef enum logic [1:0] {LOAD_NOW, LOAD_ZERO, LOAD_ZERO_PER, LOAD_OLD} load_mode_e;
  typedef enum logic [2:0] {
    OM_BIT, OM_SET, OM_TOG_RST, OM_SET_RST, OM_TOG, OM_RST, OM_TOG_SET, OM_RST_SET
  } out_mode_e;
endpackage : ccu_pkg

/* ccu_top.sv */
`timescale 1ns/10ps
`include "ccu_consts.svh"
// Summary of operation
// - Up/down: a descending counter keeps falling to zero, then new period applies.
// - Rising with new period above count: keep climbing to it.
// - Rising with new period below count: turn and count down.
// - Three or seven identical capture/compare channels.
// - Capture mode when capture select is 1, compare when 0.
// - Source from two inputs; rising, falling or both edges.
// - Capture copies count into buffer register and sets channel flag.
// - Selected input level readable at any time.
// - Sync bit delays capture to next timer clock edge.
// - Second capture before read sets overflow; only software clears it.
// - Software capture: select both edges, toggle supply/ground source.
// - Compare match sets flag, equality and drives output unit.
// - Writes go to buffer; latch loads at chosen event.
// - Mode 00 loads on write; mode 01 at count zero.
// - Mode 10: zero, or also old period in up/down.
// - Mode 11 loads when count reaches the old latch value.
// - Lowest channel of a group picks its load event; all-group uses channel 1.
// - Leading mode zero means every latch loads on its own write.
// - Group loads only after every member was written, then event.
// - Grouping 00 none, 01 pairs, 10 triples, 11 all.
// - Eight output modes; high-impedance pin floats every output.
// - Outputs change on clock edge; mode 0 follows the bit.
// - Only real counting triggers count events, not writes.
// - Up/down counts zero to period and back to zero.
module ccu_top
  import ccu_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Counter control
  input wire logic [1:0] COUNT_MODE,
  input wire logic COUNT_WR,
  input wire cnt_t COUNT_WDATA,
  input wire logic COUNT_CLR,
  input wire logic [`GRP_W-1:0] LATCH_GROUPING,
  // Channel configuration
  input wire logic [`CH_N-1:0] CAPTURE_SELECT,
  input wire logic [`CH_N-1:0][`SEL_W-1:0] EDGE_SELECT,
  input wire logic [`CH_N-1:0][`SEL_W-1:0] INPUT_SELECT,
  input wire logic [`CH_N-1:0] SYNC_CAPTURE,
  input wire logic [`CH_N-1:0][`LM_W-1:0] LATCH_LOAD_MODE,
  input wire logic [`CH_N-1:0][`OM_W-1:0] OUTPUT_MODE_SEL,
  input wire logic [`CH_N-1:0] OUT_BIT,
  // Software access
  input wire logic [`CH_N-1:0] BUF_WR,
  input wire cnt_t BUF_WDATA,
  input wire logic [`CH_N-1:0] BUF_RD,
  input wire logic [`CH_N-1:0] FLAG_CLR,
  input wire logic [`CH_N-1:0] OVERFLOW_CLR,
  // Pins
  input wire logic [`CH_N-1:0] CAPTURE_INPUT_A,
  input wire logic [`CH_N-1:0] CAPTURE_INPUT_B,
  input wire logic OUTPUTS_HIZ_PIN,
  // Status
  output cnt_t COUNT_VALUE,
  output logic COUNT_DOWN,
  output cnt_t [`CH_N-1:0] CHANNEL_BUFFER_REG,
  output logic [`CH_N-1:0] CHANNEL_FLAG,
  output logic [`CH_N-1:0] CAPTURE_OVERFLOW,
  output logic [`CH_N-1:0] INPUT_LEVEL,
  output logic [`CH_N-1:0] CHANNEL_EQUAL,
  // Timer outputs
  output logic [`CH_N-1:0] CHANNEL_OUTPUT,
  output logic [`CH_N-1:0] CHANNEL_OUTPUT_EN
);
  cnt_t count_r, count_nxt;
  logic down_r, down_nxt;
  logic stepped_r, stepped_nxt;
  cnt_t period_latch;
  logic zero_ev, per_ev;
  logic [`CH_N-1:0] hit, equ, written_r, load_go, out_r, en_r, equ_r;
  logic [`CH_N-1:0][2:0] lead;
  logic hiz_meta_r, hiz_sync_r;
  count_mode_e mode;

  cc_link_if lnk [`CH_N] ();

  assign mode = count_mode_e'(COUNT_MODE);
  assign period_latch = lnk[0].latch;

  // Counter
  always_comb begin
    count_nxt = count_r;
    down_nxt = down_r;
    stepped_nxt = 1'b0;
    if (COUNT_CLR) begin
      count_nxt = `CNT_RST;
      down_nxt = 1'b0;
    end else if (COUNT_WR) begin
      // Direct writes land without a counting step
      count_nxt = COUNT_WDATA;
    end else begin
      unique case (mode)
        MODE_STOP: begin
          stepped_nxt = 1'b0;
        end
        MODE_UP: begin
          if (period_latch != `CNT_RST) begin
            stepped_nxt = 1'b1;
            if (count_r >= period_latch) count_nxt = `CNT_RST;
            else count_nxt = cnt_t'(count_r + 1'b1);
          end
        end
        MODE_CONT: begin
          stepped_nxt = 1'b1;
          count_nxt = cnt_t'(count_r + 1'b1);
        end
        MODE_UPDN: begin
          if (period_latch != `CNT_RST) begin
            stepped_nxt = 1'b1;
            if (down_r) begin
              // Descent ignores the period until zero
              if (count_r == `CNT_RST) begin
                down_nxt = 1'b0;
                count_nxt = cnt_t'(count_r + 1'b1);
              end else begin
                count_nxt = cnt_t'(count_r - 1'b1);
              end
            end else if (count_r >= period_latch) begin
              // Also turns when a smaller period arrives mid-climb
              down_nxt = 1'b1;
              count_nxt = cnt_t'(count_r - 1'b1);
            end else begin
              count_nxt = cnt_t'(count_r + 1'b1);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      count_r <= `CNT_RST;
      down_r <= 1'b0;
      stepped_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      down_r <= down_nxt;
      stepped_r <= stepped_nxt;
    end
  end

  // Count events, only after a real step
  assign zero_ev = stepped_r & (count_r == `CNT_RST);
  assign per_ev = stepped_r & (count_r == period_latch);

  // Group leader of each channel
  function automatic logic [2:0] lead_of(input int unsigned i,
                                         input logic [`GRP_W-1:0] g);
    logic [2:0] l;
    l = 3'(i);
    unique case (g)
      2'h0: l = 3'(i);
      2'h1: l = (i == 0) ? 3'h0 : 3'(((i - 1) / 2) * 2 + 1);
      2'h2: l = (i == 0) ? 3'h0 : ((i <= 3) ? 3'h1 : 3'h4);
      default: l = 3'h1;
    endcase
    return l;
  endfunction : lead_of

  function automatic logic load_event(input load_mode_e m, input logic zero,
                                      input logic per, input logic updn,
                                      input logic own_hit);
    logic ev;
    ev = 1'b0;
    unique case (m)
      LOAD_NOW: ev = 1'b1;
      LOAD_ZERO: ev = zero;
      LOAD_ZERO_PER: ev = zero | (updn & per);
      LOAD_OLD: ev = own_hit;
    endcase
    return ev;
  endfunction : load_event

  // Load decision per channel
  always_comb begin
    logic all_written;
    logic [`LM_W-1:0] lm;
    all_written = 1'b0;
    lm = '0;
    for (int i = 0; i < `CH_N; i++) begin
      lead[i] = lead_of(i, LATCH_GROUPING);
      lm = LATCH_LOAD_MODE[lead[i]];
      if (lm == `LM_W'(LOAD_NOW)) begin
        // Leader at zero breaks up the groups
        lead[i] = 3'(i);
        lm = `LM_W'(LOAD_NOW);
        all_written = written_r[i];
      end else begin
        all_written = 1'b1;
        for (int j = 0; j < `CH_N; j++) begin
          if (lead_of(j, LATCH_GROUPING) == lead[i] && !written_r[j])
            all_written = 1'b0;
        end
      end
      load_go[i] = all_written & load_event(load_mode_e'(lm), zero_ev, per_ev,
                                            mode == MODE_UPDN,
                                            hit[lead[i]]);
    end
  end

  // Written marks, a new write wins over the load that clears
  always_ff @(posedge CLK) begin
    if (RST) written_r <= '0;
    else written_r <= BUF_WR | (written_r & ~load_go);
  end

  // Channels
  for (genvar g = 0; g < `CH_N; g++) begin : g_ch
    assign lnk[g].count = count_r;
    assign lnk[g].stepped = stepped_r;
    assign lnk[g].load_go = load_go[g];
    assign hit[g] = lnk[g].hit;
    assign equ[g] = lnk[g].equ;

    cc_channel u_ch (
      .clk(CLK),
      .rst(RST),
      .cap_sel(CAPTURE_SELECT[g]),
      .edge_sel(EDGE_SELECT[g]),
      .in_sel(INPUT_SELECT[g]),
      .sync_cap(SYNC_CAPTURE[g]),
      .in_a(CAPTURE_INPUT_A[g]),
      .in_b(CAPTURE_INPUT_B[g]),
      .buf_wr(BUF_WR[g]),
      .wdata(BUF_WDATA),
      .buf_rd(BUF_RD[g]),
      .flag_clr(FLAG_CLR[g]),
      .cov_clr(OVERFLOW_CLR[g]),
      .lnk(lnk[g])
    );

    assign CHANNEL_BUFFER_REG[g] = lnk[g].buffer;
    assign CHANNEL_FLAG[g] = lnk[g].flag;
    assign CAPTURE_OVERFLOW[g] = lnk[g].cov;
    assign INPUT_LEVEL[g] = lnk[g].level;

    // Output unit; in modes 2, 3, 6 and 7 period equality wins when both fire
    always_ff @(posedge CLK) begin
      if (RST) begin
        out_r[g] <= `OUT_RST;
      end else begin
        unique case (out_mode_e'(OUTPUT_MODE_SEL[g]))
          OM_BIT: out_r[g] <= OUT_BIT[g];
          OM_SET: if (equ[g]) out_r[g] <= 1'b1;
          OM_TOG_RST: begin
            if (equ[0]) out_r[g] <= 1'b0;
            else if (equ[g]) out_r[g] <= ~out_r[g];
          end
          OM_SET_RST: begin
            if (equ[0]) out_r[g] <= 1'b0;
            else if (equ[g]) out_r[g] <= 1'b1;
          end
          OM_TOG: if (equ[g]) out_r[g] <= ~out_r[g];
          OM_RST: if (equ[g]) out_r[g] <= 1'b0;
          OM_TOG_SET: begin
            if (equ[0]) out_r[g] <= 1'b1;
            else if (equ[g]) out_r[g] <= ~out_r[g];
          end
          OM_RST_SET: begin
            if (equ[0]) out_r[g] <= 1'b1;
            else if (equ[g]) out_r[g] <= 1'b0;
          end
        endcase
      end
    end

    a_out_set: assert property (@(posedge CLK) disable iff (RST)
      OUTPUT_MODE_SEL[g] == `OM_W'(OM_SET) && equ[g] |=> out_r[g])
      else $error("set mode output did not rise on equality");
    a_latch_load: assert property (@(posedge CLK) disable iff (RST)
      load_go[g] |=> lnk[g].latch == $past(lnk[g].buffer))
      else $error("latch did not take buffer value");
    a_group_wait: assert property (@(posedge CLK) disable iff (RST)
      load_go[g] |-> written_r[g] && written_r[lead[g]])
      else $error("group loaded before all writes");
  end

  // High-impedance pin is asynchronous
  always_ff @(posedge CLK) begin
    if (RST) begin
      hiz_meta_r <= 1'b0;
      hiz_sync_r <= 1'b0;
    end else begin
      hiz_meta_r <= OUTPUTS_HIZ_PIN;
      hiz_sync_r <= hiz_meta_r;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      en_r <= '0;
      equ_r <= '0;
    end else begin
      en_r <= {`CH_N{~hiz_sync_r}};
      equ_r <= equ;
    end
  end

  assign COUNT_VALUE = count_r;
  assign COUNT_DOWN = down_r;
  assign CHANNEL_EQUAL = equ_r;
  assign CHANNEL_OUTPUT = out_r;
  assign CHANNEL_OUTPUT_EN = en_r;

  a_down_to_zero: assert property (@(posedge CLK) disable iff (RST)
    mode == MODE_UPDN && down_r && count_r != `CNT_RST && period_latch != `CNT_RST
    && !COUNT_WR && !COUNT_CLR |=> down_r && count_r == $past(count_r) - 1'b1)
    else $error("descent interrupted before zero");
  a_climb_period: assert property (@(posedge CLK) disable iff (RST)
    mode == MODE_UPDN && !down_r && count_r < period_latch
    && !COUNT_WR && !COUNT_CLR |=> !down_r && count_r == $past(count_r) + 1'b1)
    else $error("climb to period interrupted");
  a_reverse_down: assert property (@(posedge CLK) disable iff (RST)
    mode == MODE_UPDN && !down_r && count_r > period_latch && period_latch != `CNT_RST
    && !COUNT_WR && !COUNT_CLR |=> down_r)
    else $error("no reversal above new period");
  a_write_no_event: assert property (@(posedge CLK) disable iff (RST)
    COUNT_WR && !COUNT_CLR |=> !stepped_r && !zero_ev && !per_ev)
    else $error("write produced a count event");
  a_hiz_outputs: assert property (@(posedge CLK) disable iff (RST)
    OUTPUTS_HIZ_PIN [*3] |=> CHANNEL_OUTPUT_EN == '0)
    else $error("outputs still driven in high impedance");
endmodule : ccu_top

/* tb_top.sv */
`timescale 1ns/10ps
`include "ccu_consts.svh"
module tb_top
  import ccu_pkg::*;
;
  typedef struct packed {logic [2:0] m; logic b; logic ea; logic eb;} row_s;
  row_s rows [8] = '{'{3'h0, 1'h1, 1'h1, 1'h1}, '{3'h1, 1'h0, 1'h1, 1'h1},
    '{3'h2, 1'h0, 1'h1, 1'h0}, '{3'h3, 1'h0, 1'h1, 1'h0}, '{3'h4, 1'h0, 1'h1, 1'h1},
    '{3'h5, 1'h0, 1'h0, 1'h0}, '{3'h6, 1'h0, 1'h1, 1'h1}, '{3'h7, 1'h0, 1'h0, 1'h1}};
  logic clk, rst, count_wr, count_clr, hiz_req, count_down, hiz_pin;
  logic [1:0] count_mode;
  logic [`GRP_W-1:0] grouping;
  cnt_t count_wdata, buf_wdata, count_value, c0, prev;
  cnt_t [`CH_N-1:0] buf_reg;
  logic [`CH_N-1:0] capt_sel, sync_cap, out_bit, buf_wr, buf_rd, flag_clr, ovf_clr;
  logic [`CH_N-1:0] drv_a, drv_b, pin_a, pin_b, flag, ovf, level, equal, out_q, out_en;
  logic [`CH_N-1:0] pin_level;
  logic [`CH_N-1:0][`SEL_W-1:0] edge_sel, in_sel;
  logic [`CH_N-1:0][`LM_W-1:0] load_mode;
  logic [`CH_N-1:0][`OM_W-1:0] out_mode;
  int fails, comparisons, h6, h16;

  ccu_top dut (.CLK(clk), .RST(rst), .COUNT_MODE(count_mode), .COUNT_WR(count_wr),
    .COUNT_WDATA(count_wdata), .COUNT_CLR(count_clr), .LATCH_GROUPING(grouping),
    .CAPTURE_SELECT(capt_sel), .EDGE_SELECT(edge_sel), .INPUT_SELECT(in_sel),
    .SYNC_CAPTURE(sync_cap), .LATCH_LOAD_MODE(load_mode), .OUTPUT_MODE_SEL(out_mode),
    .OUT_BIT(out_bit), .BUF_WR(buf_wr), .BUF_WDATA(buf_wdata), .BUF_RD(buf_rd),
    .FLAG_CLR(flag_clr), .OVERFLOW_CLR(ovf_clr), .CAPTURE_INPUT_A(pin_a),
    .CAPTURE_INPUT_B(pin_b), .OUTPUTS_HIZ_PIN(hiz_pin), .COUNT_VALUE(count_value),
    .COUNT_DOWN(count_down), .CHANNEL_BUFFER_REG(buf_reg), .CHANNEL_FLAG(flag),
    .CAPTURE_OVERFLOW(ovf), .INPUT_LEVEL(level), .CHANNEL_EQUAL(equal),
    .CHANNEL_OUTPUT(out_q), .CHANNEL_OUTPUT_EN(out_en));

  ccu_far_side far (.clk(clk), .set_a(drv_a), .set_b(drv_b), .hiz_req(hiz_req),
    .pin_a(pin_a), .pin_b(pin_b), .hiz_pin(hiz_pin), .out_val(out_q), .out_en(out_en),
    .pin_level(pin_level));

  always #5 clk = ~clk;

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task close_out;
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task do_reset;
    @(posedge clk);
    rst <= 1'h1;
    count_mode <= 2'h0;
    grouping <= 2'h0;
    capt_sel <= '0;
    tick(3);
    rst <= 1'h0;
  endtask : do_reset

  task wr_buf(input int ch, input cnt_t v);
    @(posedge clk);
    buf_wr[ch] <= 1'h1;
    buf_wdata <= v;
    @(posedge clk);
    buf_wr[ch] <= 1'h0;
  endtask : wr_buf

  task wait_count(input cnt_t v);
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge clk);
      #1;
      if (count_value === v) break;
    end
    if (i == 400) check(count_value, v);
  endtask : wait_count

  // Equality pulse lags its hit by one cycle, so the count has moved on by one
  task watch(input int ch, input cnt_t at, output int hits);
    hits = 0;
    repeat (70) begin
      @(posedge clk);
      #1;
      if (equal[ch] === 1'h1 && count_value === cnt_t'(at + 1)) hits++;
    end
  endtask : watch

  // Pulses on software clear and read bits; one cycle each
  task sw_pulse(input int kind, input int ch);
    @(posedge clk);
    if (kind == 0) flag_clr[ch] <= 1'h1;
    else if (kind == 1) ovf_clr[ch] <= 1'h1;
    else buf_rd[ch] <= 1'h1;
    @(posedge clk);
    flag_clr <= '0;
    ovf_clr <= '0;
    buf_rd <= '0;
  endtask : sw_pulse

  initial begin
    #500000;
    fails++;
    close_out();
  end

  initial begin
    clk = 1'h0;
    rst = 1'h1;
    {count_wr, count_clr, hiz_req} = '0;
    count_mode = '0;
    grouping = '0;
    {count_wdata, buf_wdata} = '0;
    {capt_sel, sync_cap, out_bit, buf_wr, buf_rd, flag_clr, ovf_clr, drv_a, drv_b} = '0;
    {edge_sel, in_sel, load_mode, out_mode} = '0;
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    foreach (rows[i]) begin
      do_reset();
      out_mode[1] <= rows[i].m;
      out_bit[1] <= rows[i].b;
      wr_buf(0, 16'h0014);
      wr_buf(1, 16'h000A);
      tick(2);
      count_mode <= 2'h1;
      wait_count(16'h000C);
      check(out_q[1], rows[i].ea);
      check(flag[1], 1'h1);
      wait_count(16'h0002);
      check(out_q[1], rows[i].eb);
      check(pin_level[1], out_q[1]);
    end
    // Reset in mid-run
    do_reset();
    #1;
    check({count_value, out_q, flag}, '0);
    // Up/down turning and period changes
    wr_buf(0, 16'h001E);
    count_mode <= 2'h3;
    wait_count(16'h001E);
    tick(1);
    #1;
    check({count_down, count_value}, {1'h1, 16'h001D});
    wr_buf(0, 16'h000A);
    wait_count(16'h0000);
    wait_count(16'h000A);
    tick(2);
    #1;
    check({count_down, count_value}, {1'h1, 16'h0008});
    wait_count(16'h0000);
    wait_count(16'h0003);
    wr_buf(0, 16'h0019);
    wait_count(16'h0014);
    check(count_down, 1'h0);
    wr_buf(0, 16'h0005);
    tick(4);
    #1;
    check(count_down, 1'h1);
    // Direct counter write is not counting
    do_reset();
    wr_buf(1, 16'h0028);
    sw_pulse(0, 1);
    count_wdata <= 16'h0028;
    count_wr <= 1'h1;
    count_mode <= 2'h2;
    @(posedge clk);
    count_wr <= 1'h0;
    tick(3);
    #1;
    check(flag[1], 1'h0);
    @(posedge clk);
    count_wdata <= 16'h0026;
    count_wr <= 1'h1;
    @(posedge clk);
    count_wr <= 1'h0;
    count_mode <= 2'h2;
    tick(5);
    #1;
    check(flag[1], 1'h1);
    @(posedge clk);
    // Capture on pin A, rising only, aligned
    capt_sel[2] <= 1'h1;
    in_sel[2] <= `SEL_A;
    edge_sel[2] <= `EDGE_RISE;
    sync_cap[2] <= 1'h1;
    tick(4);
    drv_a[2] <= 1'h1;
    #1;
    c0 = count_value;
    tick(10);
    #1;
    check(level[2], 1'h1);
    check(flag[2], 1'h1);
    check(buf_reg[2], cnt_t'(c0 + 16'h0003));
    prev = buf_reg[2];
    drv_a[2] <= 1'h0;
    tick(10);
    check(buf_reg[2], prev);
    check(ovf[2], 1'h0);
    drv_a[2] <= 1'h1;
    tick(10);
    check(ovf[2], 1'h1);
    sw_pulse(1, 2);
    tick(1);
    #1;
    check(ovf[2], 1'h0);
    @(posedge clk);
    // Software capture by switching supply and ground
    capt_sel[3] <= 1'h1;
    in_sel[3] <= `SEL_GND;
    edge_sel[3] <= `EDGE_BOTH;
    tick(6);
    for (int k = 1; k >= 0; k--) begin
      sw_pulse(2, 3);
      sw_pulse(0, 3);
      prev = buf_reg[3];
      in_sel[3] <= {1'h1, k[0]};
      tick(8);
      #1;
      check(level[3], k[0]);
      check({flag[3], buf_reg[3] !== prev}, 2'h3);
    end
    // Grouped latches load only when every member was written
    do_reset();
    wr_buf(0, 16'h001E);
    wr_buf(2, 16'h0005);
    tick(1);
    count_mode <= 2'h1;
    grouping <= 2'h1;
    load_mode[1] <= 2'h1;
    wr_buf(2, 16'h000F);
    watch(2, 16'h0005, h6);
    check(h6 > 0, 1'h1);
    watch(2, 16'h000F, h16);
    check(h16, 0);
    wr_buf(1, 16'h0019);
    tick(35);
    watch(2, 16'h000F, h16);
    check(h16 > 0, 1'h1);
    // All outputs float while the pin is high
    hiz_req <= 1'h1;
    tick(6);
    #1;
    check(out_en, '0);
    hiz_req <= 1'h0;
    tick(6);
    #1;
    check(out_en, 7'h7F);
    close_out();
  end
endmodule : tb_top
